// ---- verilog/pssp_top.sv ----
// pipelined synchronous sram port with apb status and read capture fifo
// Behaviour
// - sleep input high puts the port in low-power standby; held low normally.
// - write data in and read data out are both registered on rising clock.
// - address captured only with load low, clock enable low, chips enabled.
// - two lowest address bits seed the burst counter when a burst starts.
// - one active-low write enable per 9-bit lane, gating only that lane.
// - lane enables are ignored when a load samples read/write select high or a read burst advances.
// - enabled write bytes land two cycles after the command; data follows.
// - narrow organisation has two lanes; enable a for a, b for b.
// - clock enable high freezes inputs, outputs and the port pipeline; pin synchronisers and apb registers keep running.
// - advance high steps the burst; address and read/write are ignored.
// - burst-order input high selects interleaved order, low selects linear.
// - data bus activity occurs two cycles after the command is sampled.
//
// Decided for this implementation: the APB register port and the address map.
`include "pssp_params.svh"
module pssp_top #(
    parameter int LANE_W     = `PSSP_LANE_W,
    parameter int LANES      = `PSSP_LANES,
    parameter int ADDR_W     = `PSSP_ADDR_W,
    parameter int FIFO_DEPTH = `PSSP_FIFO_DEPTH,
    parameter int DATA_W     = LANE_W * LANES
) (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic                     cke_n,
    input  wire logic                     advance_or_load,
    input  wire logic                     read_write,
    input  wire logic                     chip_select_n,
    input  wire logic                     chip_select2_n,
    input  wire logic                     chip_select_high,
    input  wire logic [ADDR_W-1:2]        upper_address_inputs,
    input  wire logic                     addr_bit_one,
    input  wire logic                     addr_bit_zero,
    input  wire logic [LANES-1:0]         lane_write_en_n,
    input  wire logic                     sleep_request,
    input  wire logic                     burst_mode,
    input  wire logic [DATA_W-1:0]        data_lane_in,
    output wire logic [DATA_W-1:0]        data_lane_out,
    output wire logic                     data_lane_oe,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`PSSP_APB_AW-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output wire logic [31:0]              prdata,
    output wire logic                     pready,
    output wire logic                     pslverr
);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    // ------------------------------------------------------------------------
    // pin synchronisers and clock enable
    // ------------------------------------------------------------------------
    logic sleep_s1_q;
    logic sleep_s2_q;
    logic mode_s1_q;
    logic mode_s2_q;
    logic [`PSSP_CTRL_W-1:0] ctrl_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
            mode_s1_q  <= 1'b1;
            mode_s2_q  <= 1'b1;
        end else begin
            sleep_s1_q <= sleep_request;
            sleep_s2_q <= sleep_s1_q;
            mode_s1_q  <= burst_mode;
            mode_s2_q  <= mode_s1_q;
        end
    end

    wire en        = !cke_n;
    wire sleep_act = sleep_s2_q || ctrl_q[`PSSP_CTRL_SLEEP];
    wire selected  = !chip_select_n && !chip_select2_n && chip_select_high;

    // ------------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------------
    logic              active_q;
    logic              bwr_q;
    logic [ADDR_W-1:2] base_q;
    wire  [1:0]        low_adv;

    // standby is treated as a deselect so no new burst loads while asleep; advances of an open burst still run
    wire load_go = en && !advance_or_load && selected && !sleep_act;
    wire desel_go = en && !advance_or_load && !(selected && !sleep_act);
    wire adv_go = en && advance_or_load && active_q;
    wire cmd_v = load_go || adv_go;
    wire cmd_wr = load_go ? !read_write : bwr_q;
    wire [ADDR_W-1:0] cmd_addr = load_go
        ? {upper_address_inputs, addr_bit_one, addr_bit_zero}
        : {base_q, low_adv};
    wire [LANES-1:0] cmd_be = cmd_wr ? ~lane_write_en_n : '0;

    pssp_burst u_burst (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .load_en    (load_go),
        .adv_en     (adv_go),
        .start_low  ({addr_bit_one, addr_bit_zero}),
        .interleave (mode_s2_q),
        .low_adv    (low_adv)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active_q <= 1'b0;
            bwr_q    <= 1'b0;
            base_q   <= '0;
        end else if (load_go) begin
            active_q <= 1'b1;
            bwr_q    <= !read_write;
            base_q   <= upper_address_inputs;
        end else if (desel_go) begin
            active_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // pipeline stages
    // ------------------------------------------------------------------------
    logic              s1_v_q;
    logic              s1_wr_q;
    logic [ADDR_W-1:0] s1_addr_q;
    logic [LANES-1:0]  s1_be_q;
    logic              s2_v_q;
    logic              s2_wr_q;
    logic [ADDR_W-1:0] s2_addr_q;
    logic [LANES-1:0]  s2_be_q;
    logic              w3_v_q;
    logic [ADDR_W-1:0] w3_addr_q;
    logic [LANES-1:0]  w3_be_q;
    logic [DATA_W-1:0] din_q;
    logic [DATA_W-1:0] dout_q;
    logic              oe_q;
    wire  [DATA_W-1:0] rd_word;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_v_q    <= 1'b0;
            s1_wr_q   <= 1'b0;
            s1_addr_q <= '0;
            s1_be_q   <= '0;
        end else if (en) begin
            s1_v_q    <= cmd_v;
            s1_wr_q   <= cmd_wr;
            s1_addr_q <= cmd_addr;
            s1_be_q   <= cmd_be;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s2_v_q    <= 1'b0;
            s2_wr_q   <= 1'b0;
            s2_addr_q <= '0;
            s2_be_q   <= '0;
        end else if (en) begin
            s2_v_q    <= s1_v_q && s1_wr_q;
            s2_wr_q   <= s1_wr_q;
            s2_addr_q <= s1_addr_q;
            s2_be_q   <= s1_be_q;
        end
    end

    // write data is on the lanes in the same cycle that s2 holds the write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            w3_v_q    <= 1'b0;
            w3_addr_q <= '0;
            w3_be_q   <= '0;
            din_q     <= '0;
        end else if (en) begin
            w3_v_q    <= s2_v_q;
            w3_addr_q <= s2_addr_q;
            w3_be_q   <= s2_be_q;
            din_q     <= data_lane_in;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dout_q <= '0;
            oe_q   <= 1'b0;
        end else if (en) begin
            oe_q   <= s1_v_q && !s1_wr_q && !sleep_act;
            dout_q <= (s1_v_q && !s1_wr_q) ? rd_word : dout_q;
        end
    end

    assign data_lane_out = dout_q;
    assign data_lane_oe  = oe_q;

    // ------------------------------------------------------------------------
    // array, one bank per lane
    // ------------------------------------------------------------------------
    // reads forward the two writes not yet in the array, so a read right
    // behind a write to the same word sees the new bytes
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] bank [2**ADDR_W];
        wire hit_w3 = w3_v_q && w3_be_q[g] && (w3_addr_q == s1_addr_q);
        wire hit_s2 = s2_v_q && s2_be_q[g] && (s2_addr_q == s1_addr_q);

        always_ff @(posedge ref_clk) begin
            if (en && w3_v_q && w3_be_q[g]) begin
                bank[w3_addr_q] <= din_q[g*LANE_W +: LANE_W];
            end
        end

        assign rd_word[g*LANE_W +: LANE_W] = hit_s2 ? data_lane_in[g*LANE_W +: LANE_W]
                                           : hit_w3 ? din_q[g*LANE_W +: LANE_W]
                                           : bank[s1_addr_q];
    end

    // ------------------------------------------------------------------------
    // read capture fifo
    // ------------------------------------------------------------------------
    logic [`PSSP_DROP_W-1:0] drop_q;
    wire                     cap_valid;
    wire                     cap_ready;
    wire                     cap_out_valid;
    wire                     cap_pop;
    wire [DATA_W-1:0]        cap_data;
    wire [LVL_W-1:0]         cap_level;

    assign cap_valid = en && ctrl_q[`PSSP_CTRL_CAPT] && s1_v_q && !s1_wr_q && !sleep_act;

    pssp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (rd_word),
        .out_valid (cap_out_valid),
        .out_ready (cap_pop),
        .out_data  (cap_data),
        .level     (cap_level)
    );

    // the sram side cannot wait, so a full fifo drops the capture and counts losses
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drop_q <= '0;
        end else if (cap_valid && !cap_ready) begin
            drop_q <= drop_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    function automatic pssp_pkg::pssp_reg_t reg_sel(input logic [`PSSP_APB_AW-1:0] a);
        if (a == `PSSP_OFS_CTRL) begin
            return pssp_pkg::PSSP_REG_CTRL;
        end else if (a == `PSSP_OFS_STATUS) begin
            return pssp_pkg::PSSP_REG_STATUS;
        end else if (a == `PSSP_OFS_CAPTURE) begin
            return pssp_pkg::PSSP_REG_CAPTURE;
        end else begin
            return pssp_pkg::PSSP_REG_NONE;
        end
    endfunction

    pssp_pkg::pssp_reg_t sel;
    logic [31:0]         prdata_q;
    logic [31:0]         status_w;
    logic [31:0]         capture_w;

    assign sel       = reg_sel(paddr);
    wire apb_setup   = psel && !penable;
    wire apb_access  = psel && penable;
    assign pready    = 1'b1;
    assign pslverr   = apb_access && (sel == pssp_pkg::PSSP_REG_NONE);
    assign prdata    = prdata_q;
    assign cap_pop   = apb_access && !pwrite && (sel == pssp_pkg::PSSP_REG_CAPTURE);

    always_comb begin
        status_w                                  = '0;
        status_w[`PSSP_ST_SLEEP]                  = sleep_act;
        status_w[`PSSP_ST_INTLV]                  = mode_s2_q;
        status_w[`PSSP_ST_BURST]                  = active_q;
        status_w[`PSSP_ST_LEVEL +: LVL_W]         = cap_level;
        status_w[`PSSP_ST_DROP +: `PSSP_DROP_W]   = drop_q;
        capture_w                                 = '0;
        capture_w[`PSSP_CAP_VALID]                = cap_out_valid;
        capture_w[DATA_W-1:0]                     = cap_data;
    end

    // read data is taken in the setup cycle so the zero-wait access sees it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= '0;
        end else if (apb_setup && !pwrite) begin
            prdata_q <= (sel == pssp_pkg::PSSP_REG_CTRL)    ? 32'(ctrl_q)
                      : (sel == pssp_pkg::PSSP_REG_STATUS)  ? status_w
                      : (sel == pssp_pkg::PSSP_REG_CAPTURE) ? capture_w
                      : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `PSSP_CTRL_RST;
        end else if (apb_access && pwrite && (sel == pssp_pkg::PSSP_REG_CTRL)) begin
            ctrl_q <= pwdata[`PSSP_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_read_cmd;
        load_go && read_write;
    endsequence

    sequence s_write_cmd;
        load_go && !read_write;
    endsequence

    property p_freeze;
        cke_n |=> $stable(data_lane_out) && $stable(data_lane_oe) && $stable(s1_addr_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable high");

    property p_read_two;
        s_read_cmd ##1 (en && !sleep_act) |=> data_lane_oe && data_lane_out == $past(rd_word);
    endproperty
    a_read_two: assert property (p_read_two) else $error("read data not driven two cycles on");

    property p_write_no_drive;
        s_write_cmd ##1 en |=> !data_lane_oe;
    endproperty
    a_write_no_drive: assert property (p_write_no_drive) else $error("lanes driven on write");

    property p_write_capture;
        s_write_cmd ##1 en ##1 en |=> w3_v_q && din_q == $past(data_lane_in);
    endproperty
    a_write_capture: assert property (p_write_capture) else $error("write data not captured");

    property p_addr_load;
        load_go |=> s1_v_q && s1_addr_q == $past({upper_address_inputs, addr_bit_one, addr_bit_zero});
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not captured on load");

    property p_desel;
        desel_go |=> !s1_v_q && !active_q;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect started an access");

    property p_adv_ignores_addr;
        adv_go |=> s1_addr_q[ADDR_W-1:2] == $past(base_q) && s1_wr_q == $past(bwr_q);
    endproperty
    a_adv_ignores_addr: assert property (p_adv_ignores_addr) else $error("advance used pins");

    property p_read_no_be;
        s_read_cmd |=> s1_be_q == '0;
    endproperty
    a_read_no_be: assert property (p_read_no_be) else $error("lane enables used on read");

    property p_lane_gate;
        s_write_cmd |=> s1_be_q == ~$past(lane_write_en_n);
    endproperty
    a_lane_gate: assert property (p_lane_gate) else $error("lane enable mapping wrong");

    property p_sleep_quiet;
        sleep_act && en |=> !data_lane_oe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("lanes driven in standby");
endmodule

// ---- common/pssp_params.svh ----
// constants of the pipelined synchronous sram port
`ifndef PSSP_PARAMS_SVH
`define PSSP_PARAMS_SVH

// ----------------------------------------------------------------------------
// array organisation
// ----------------------------------------------------------------------------
`define PSSP_LANE_W      9
`define PSSP_LANES       2
`define PSSP_ADDR_W      19
`define PSSP_BURST_W     2
`define PSSP_FIFO_DEPTH  16

// ----------------------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define PSSP_APB_AW      12
`define PSSP_OFS_CTRL    12'h000
`define PSSP_OFS_STATUS  12'h004
`define PSSP_OFS_CAPTURE 12'h008
`define PSSP_CTRL_W      2
`define PSSP_CTRL_RST    2'h0
`define PSSP_CTRL_CAPT   0
`define PSSP_CTRL_SLEEP  1
`define PSSP_ST_SLEEP    0
`define PSSP_ST_INTLV    1
`define PSSP_ST_BURST    2
`define PSSP_ST_LEVEL    8
`define PSSP_ST_DROP     16
`define PSSP_DROP_W      16
`define PSSP_CAP_VALID   31

`endif

// ---- common/pssp_pkg.sv ----
// types shared by the sram port design files
package pssp_pkg;

    // ------------------------------------------------------------------------
    // register selection
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSSP_REG_CTRL    = 2'b00,
        PSSP_REG_STATUS  = 2'b01,
        PSSP_REG_CAPTURE = 2'b10,
        PSSP_REG_NONE    = 2'b11
    } pssp_reg_t;

endpackage

// ---- verilog/pssp_fifo.sv ----
// capture fifo with valid/ready on both sides
`include "pssp_params.svh"
module pssp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = `PSSP_FIFO_DEPTH
) (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic                       in_valid,
    output wire logic                       in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output wire logic                       out_valid,
    input  wire logic                       out_ready,
    output wire logic [WIDTH-1:0]           out_data,
    output wire logic [$clog2(DEPTH):0]     level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    wire              push;
    wire              pop;

    assign in_ready  = (count_q != DEPTH[PW:0]);
    assign out_valid = (count_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = store[rd_ptr_q];
    assign level     = count_q;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap only when DEPTH is a power of two
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q  <= count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end
endmodule

// ---- verilog/pssp_burst.sv ----
// two-bit burst counter with linear and interleaved order
`include "pssp_params.svh"
module pssp_burst (
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire logic                     load_en,
    input  wire logic                     adv_en,
    input  wire logic [`PSSP_BURST_W-1:0] start_low,
    input  wire logic                     interleave,
    output wire logic [`PSSP_BURST_W-1:0] low_adv
);
    logic [`PSSP_BURST_W-1:0] start_q;
    logic [`PSSP_BURST_W-1:0] count_q;
    wire  [`PSSP_BURST_W-1:0] count_nx;

    assign count_nx = count_q + 2'h1;
    // wraps modulo four; a burst longer than four words repeats the sequence
    assign low_adv  = interleave ? (start_q ^ count_nx) : (start_q + count_nx);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_q <= 2'h0;
            count_q <= 2'h0;
        end else if (load_en) begin
            start_q <= start_low;
            count_q <= 2'h0;
        end else if (adv_en) begin
            count_q <= count_nx;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_linear_order;
        adv_en && !load_en && !interleave |-> low_adv == start_q + count_q + 2'h1;
    endproperty
    a_linear_order: assert property (p_linear_order) else $error("linear step wrong");

    property p_intlv_order;
        adv_en && !load_en && interleave |-> low_adv == (start_q ^ (count_q + 2'h1));
    endproperty
    a_intlv_order: assert property (p_intlv_order) else $error("interleave step wrong");
endmodule

// ---- bench/pssp_ctrl_model.sv ----
// memory controller model driving the sram port pins
module pssp_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        cke_n,
    input  wire logic [2:0]  kind,
    input  wire logic [7:0]  addr,
    input  wire logic [1:0]  ben_n,
    input  wire logic [17:0] wdata,
    output wire logic        advance_or_load,
    output wire logic        read_write,
    output wire logic        chip_select_n,
    output wire logic        chip_select2_n,
    output wire logic        chip_select_high,
    output wire logic [7:2]  upper_address_inputs,
    output wire logic        addr_bit_one,
    output wire logic        addr_bit_zero,
    output wire logic [1:0]  lane_write_en_n,
    output wire logic [17:0] data_lane_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // kind: 0 read, 1 write, 2 advance, 3..5 load with one select false
    // ----------
    logic        bwr_q = 1'b0;
    logic        v1_q  = 1'b0;
    logic [17:0] p1_q  = 18'h0;
    logic [17:0] drv_q = 18'h0;
    wire  logic  take  = (kind == 3'h1) || (kind == 3'h2 && bwr_q);
    // read_write is left high on advance so a write burst must ignore it
    assign advance_or_load  = (kind == 3'h2);
    assign read_write       = (kind != 3'h1);
    assign chip_select_n    = (kind == 3'h3);
    assign chip_select2_n   = (kind == 3'h4);
    assign chip_select_high = (kind != 3'h5);
    assign {upper_address_inputs, addr_bit_one, addr_bit_zero} = addr;
    assign lane_write_en_n  = ben_n;
    // idle lanes toggle so a stray capture cannot look like real data
    always_ff @(posedge ref_clk) begin
        if (!cke_n) begin
            if (kind != 3'h2) bwr_q <= (kind == 3'h1);
            v1_q  <= take;
            p1_q  <= wdata;
            drv_q <= v1_q ? p1_q : ~drv_q;
        end
    end
    assign data_lane_in = drv_q;
endmodule

// ---- bench/pssp_top_test.sv ----
// self-checking bench for the pipelined sram port
module pssp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // stimulus and observation
    // ----------
    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        cke_n   = 1'b0;
    logic        sleep_request = 1'b0;
    logic        burst_mode = 1'b0;
    logic [2:0]  kind    = 3'h3;
    logic [7:0]  addr    = 8'h00;
    logic [1:0]  ben_n   = 2'h3;
    logic [17:0] wdata   = 18'h0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] rd;
    logic        err;
    logic [17:0] got[$];
    logic [17:0] exp[$];
    int          miscompares = 0;
    int          checked = 0;
    wire logic   adv, rw, cs_n, cs2_n, cs_hi, a1, a0, oe, pready, pslverr;
    wire logic [7:2]  ua;
    wire logic [1:0]  wen_n;
    wire logic [17:0] din, dout;
    wire logic [31:0] prdata;
    pssp_ctrl_model pssp_ctrl_model_inst (
        .ref_clk(ref_clk), .cke_n(cke_n), .kind(kind), .addr(addr), .ben_n(ben_n),
        .wdata(wdata), .advance_or_load(adv), .read_write(rw), .chip_select_n(cs_n),
        .chip_select2_n(cs2_n), .chip_select_high(cs_hi), .upper_address_inputs(ua),
        .addr_bit_one(a1), .addr_bit_zero(a0), .lane_write_en_n(wen_n), .data_lane_in(din));
    pssp_top #(.ADDR_W(8)) pssp_top_inst (
        .ref_clk(ref_clk), .resetn(resetn), .cke_n(cke_n), .advance_or_load(adv),
        .read_write(rw), .chip_select_n(cs_n), .chip_select2_n(cs2_n),
        .chip_select_high(cs_hi), .upper_address_inputs(ua), .addr_bit_one(a1),
        .addr_bit_zero(a0), .lane_write_en_n(wen_n), .sleep_request(sleep_request),
        .burst_mode(burst_mode), .data_lane_in(din), .data_lane_out(dout),
        .data_lane_oe(oe), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // one word per enabled edge; a frozen edge repeats nothing
    always @(posedge ref_clk) begin
        if (cke_n === 1'b0 && oe === 1'b1) got.push_back(dout);
    end
    // ----------
    // shared tasks
    // ----------
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmd(input logic [2:0] k, input logic [7:0] a, input logic [1:0] b,
                       input logic [17:0] d);
        @(posedge ref_clk);
        kind  <= k;
        addr  <= a;
        ben_n <= b;
        wdata <= d;
    endtask
    task automatic idle(input int n);
        repeat (n) cmd(3'h3, 8'h00, 2'h3, 18'h0);
    endtask
    task automatic check_q();
        cmp(32'(got.size()), 32'(exp.size()));
        foreach (exp[i]) cmp(32'(got[i]), 32'(exp[i]));
        got.delete();
        exp.delete();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_lanes();
        cmd(3'h1, 8'h10, 2'h0, 18'h2A5A5);
        cmd(3'h1, 8'h10, 2'h2, 18'h1C3C3);
        cmd(3'h0, 8'h10, 2'h0, 18'h0);
        cmd(3'h0, 8'h10, 2'h3, 18'h0);
        idle(4);
        repeat (2) exp.push_back({9'h152, 9'h1C3});
        check_q();
        $display("lanes test done");
    endtask
    task automatic t_burst();
        cmd(3'h1, 8'h20, 2'h0, 18'h3F0);
        for (int i = 1; i < 4; i++) cmd(3'h2, 8'hC5, 2'h0, 18'(18'h3F0 + i));
        for (int m = 0; m < 2; m++) begin
            int st;
            st = 3 - m;
            burst_mode <= m[0];
            idle(3);
            got.delete();
            cmd(3'h0, 8'(8'h20 + st), 2'h3, 18'h0);
            repeat (4) cmd(3'h2, 8'h00, 2'h3, 18'h0);
            idle(4);
            for (int n = 0; n < 5; n++)
                exp.push_back(18'(18'h3F0 + (m ? (st ^ (n % 4)) : ((st + n) % 4))));
            check_q();
        end
        $display("burst test done");
    endtask
    task automatic t_timing();
        idle(2);
        cmd(3'h0, 8'h20, 2'h3, 18'h0);
        idle(1);
        #1 cmp(32'(oe), 32'h0);
        @(posedge ref_clk);
        #1 cmp(32'(oe), 32'h1);
        cmp(32'(dout), 32'h3F0);
        cmd(3'h0, 8'h21, 2'h3, 18'h0);
        @(posedge ref_clk);
        cke_n <= 1'b1;
        kind  <= 3'h1;
        addr  <= 8'h23;
        repeat (3) @(posedge ref_clk);
        cke_n <= 1'b0;
        kind  <= 3'h3;
        #1 cmp(32'(oe), 32'h0);
        @(posedge ref_clk);
        #1 cmp(32'(oe), 32'h1);
        cmp(32'(dout), 32'h3F1);
        idle(3);
        got.delete();
        for (int k = 3; k < 6; k++) cmd(3'(k), 8'h20, 2'h3, 18'h0);
        idle(4);
        check_q();
        $display("timing test done");
    endtask
    task automatic t_sleep();
        apb(1'b0, 12'h000, 32'h0);
        cmp(rd, 32'h0);
        sleep_request <= 1'b1;
        idle(3);
        cmd(3'h0, 8'h20, 2'h3, 18'h0);
        idle(4);
        check_q();
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd & 32'h1, 32'h1);
        sleep_request <= 1'b0;
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd & 32'h1, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        cmp({rd[30:0], err}, 32'h1);
        $display("sleep test done");
    endtask
    task automatic t_fifo();
        apb(1'b1, 12'h000, 32'h1);
        cmd(3'h0, 8'h20, 2'h3, 18'h0);
        repeat (19) cmd(3'h2, 8'h00, 2'h3, 18'h0);
        idle(4);
        for (int n = 0; n < 20; n++) exp.push_back(18'(18'h3F0 + n % 4));
        check_q();
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd, 32'h0004_1002);
        for (int n = 0; n < 16; n++) begin
            apb(1'b0, 12'h008, 32'h0);
            cmp(rd, {1'b1, 13'h0, 18'(18'h3F0 + n % 4)});
        end
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd & 32'h8000_0000, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd & 32'h0000_1F00, 32'h0);
        $display("fifo test done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        t_lanes();
        t_burst();
        t_timing();
        t_sleep();
        t_fifo();
        give_verdict();
    end
    // the tests need a few hundred cycles at most
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end
endmodule
